// file: core/cit_pkg.sv
// Purpose: Shared constants and carrier types for the instruction core.
// Assumes: One system clock, asynchronous active-low reset.
// Notes:   Direct addresses below SFR_BASE reach internal RAM.

package cit_pkg;

   // ---------------------------------------------------------------
   // Reset values and address map
   // ---------------------------------------------------------------
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] SP_RESET = 8'h07;
   localparam logic [7:0] SFR_BASE = 8'h80;
   localparam logic [7:0] A_SP = 8'h81;
   localparam logic [7:0] A_DPL = 8'h82;
   localparam logic [7:0] A_DPH = 8'h83;
   localparam logic [7:0] A_FLCTL = 8'h8F;
   localparam logic [7:0] A_PSW = 8'hD0;
   localparam logic [7:0] A_ACC = 8'hE0;
   localparam logic [7:0] A_B = 8'hF0;
   localparam int IRAM_BYTES = 256;
   localparam int SFR_BYTES = 128;

   // ---------------------------------------------------------------
   // Status word bit positions
   // ---------------------------------------------------------------
   localparam int PSW_CY = 7;
   localparam int PSW_AC = 6;
   localparam int PSW_RS1 = 4;
   localparam int PSW_RS0 = 3;
   localparam int PSW_OV = 2;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic {
      M_RUN = 1'b0,
      M_HALT = 1'b1
   } cit_mode_e;

   typedef struct packed {
      logic halt;
      logic run;
      logic step;
      logic bp_en;
      logic [15:0] bp_addr;
   } cit_dbg_ctl_s;

   typedef struct packed {
      logic req;
      logic we;
      logic special_function_register_space;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cit_dbg_mem_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
      logic flash;
   } cit_ext_s;

   typedef struct packed {
      logic [1:0] len;
      logic [3:0] clk;
   } cit_timing_s;

endpackage : cit_pkg

// file: core/cit_core.sv
// Purpose: Clock-counted 8-bit instruction core with debug hooks.
// Assumes: Code memory answers combinationally; external move reads answer the clock after the read pulse.
// Notes:   Opcodes outside the decoded set run as one-byte no-ops.
//
// Behaviour
// - Sequence in whole clocks, no machine cycles.
// - Clocks equal instruction bytes for most.
// - Untaken conditional branch one clock shorter.
// - No instruction exceeds eight clocks.
// - Instruction set timing classes as specified.
// - Standard opcodes, addressing and status flags.
// - Code load and external move reach flash.
// - Static core, one instruction per clock peak.
// - Debug halt, step, breakpoints, memory access.
// - 256-byte RAM plus 128-byte SPECIAL_FUNCTION_REGISTER_SPACE space.

`timescale 1ns/1ps

module cit_core
   import cit_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   output logic [15:0] code_addr,
   input wire logic [7:0] code_rdata,
   output cit_ext_s ext,
   input wire logic [7:0] ext_rdata,
   input wire cit_dbg_ctl_s dbg_ctl,
   input wire cit_dbg_mem_s dbg_mem,
   output logic [7:0] dbg_mem_rdata,
   output logic dbg_mem_ack,
   output logic dbg_halted,
   output logic [15:0] dbg_pc
);

   // ---------------------------------------------------------------
   // Timing decode
   // ---------------------------------------------------------------
   function automatic cit_timing_s op_timing(input logic [7:0] op);
      cit_timing_s t;
      t = '{2'd1, 4'h1};
      casez (op)
         8'h02: t = '{2'd3, 4'h4};
         8'h75, 8'h90, 8'h43, 8'h53, 8'h63: t = '{2'd3, 4'h3};
         8'b???0_0001: t = '{2'd2, 4'h3};
         8'h80, 8'h40, 8'h50, 8'h60, 8'h70: t = '{2'd2, 4'h2};
         8'h05, 8'h15, 8'hC0, 8'hD0, 8'hE5, 8'hF5, 8'h74,
         8'h76, 8'h77, 8'b0111_1???: t = '{2'd2, 4'h2};
         8'b0010_010?, 8'b0011_010?, 8'b1001_010?,
         8'h44, 8'h45, 8'h54, 8'h55, 8'b0110_010?: t = '{2'd2, 4'h2};
         8'h42, 8'h52, 8'h62: t = '{2'd2, 4'h2};
         8'b000?_011?, 8'b111?_011?, 8'b0010_011?, 8'b0011_011?,
         8'b1001_011?, 8'b010?_011?, 8'b0110_011?: t = '{2'd1, 4'h2};
         8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3,
         8'h83, 8'h93: t = '{2'd1, 4'h3};
         8'hA4: t = '{2'd1, 4'h4};
         8'h84: t = '{2'd1, 4'h8};
         default: t = '{2'd1, 4'h1};
      endcase
      return t;
   endfunction : op_timing

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [7:0] iram [IRAM_BYTES];
   logic [7:0] sfr_ram [SFR_BYTES];
   logic [7:0] acc, b, program_status_word, sp, flash_ctl;
   logic [15:0] pc, dptr;
   logic [2:0] cyc;
   logic [7:0] opcode_r, op1, op2;
   cit_mode_e mode;
   logic step_armed, step_hit, bp_skip;

   logic [7:0] next_acc, next_b, next_psw, next_sp;
   logic [15:0] next_pc, next_dptr, next_code_addr;
   logic w_en, w_ind;
   logic [7:0] w_addr, w_data;

   // ---------------------------------------------------------------
   // Operand selection
   // ---------------------------------------------------------------
   wire [7:0] op = (cyc == 3'd0) ? code_rdata : opcode_r;
   wire [7:0] b1 = (cyc == 3'd1) ? code_rdata : op1;
   wire [7:0] b2 = (cyc == 3'd2) ? code_rdata : op2;
   wire [3:0] lo = op[3:0];
   wire [3:0] hi = op[7:4];
   wire halted = (mode == M_HALT);
   wire [1:0] rs = program_status_word[PSW_RS1:PSW_RS0];
   wire cy = program_status_word[PSW_CY];
   wire [7:0] psw_full = {program_status_word[7:1], ^acc};
   wire [7:0] rn_addr = {3'b000, rs, op[2:0]};
   wire [7:0] ri_addr = {3'b000, rs, 2'b00, op[0]};
   wire [7:0] ri_ptr = iram[ri_addr];
   wire [7:0] ri_val = iram[ri_ptr];
   wire [7:0] rn_val = iram[rn_addr];
   wire [7:0] dir_addr = halted ? dbg_mem.addr : b1;
   wire [7:0] dir_val =
      (dir_addr < SFR_BASE) ? iram[dir_addr] :
      (dir_addr == A_ACC) ? acc :
      (dir_addr == A_B) ? b :
      (dir_addr == A_PSW) ? psw_full :
      (dir_addr == A_SP) ? sp :
      (dir_addr == A_DPL) ? dptr[7:0] :
      (dir_addr == A_DPH) ? dptr[15:8] :
      (dir_addr == A_FLCTL) ? flash_ctl : sfr_ram[dir_addr[6:0]];
   wire [7:0] src = (lo == 4'h4) ? b1 :
                    (lo == 4'h5) ? dir_val :
                    (lo[3:1] == 3'b011) ? ri_val : rn_val;
   wire dst_ind = (lo != 4'h5);
   wire [7:0] dst_addr = (lo == 4'h5) ? b1 : (lo[3] ? rn_addr : ri_ptr);

   // ---------------------------------------------------------------
   // Arithmetic and logic
   // ---------------------------------------------------------------
   wire is_sub = (hi == 4'h9);
   wire cin = (hi == 4'h3) ? cy : (is_sub & ~cy);
   wire [7:0] addend = is_sub ? ~src : src;
   wire [8:0] sum9 = {1'b0, acc} + {1'b0, addend} + {8'h00, cin};
   wire [4:0] nib5 = {1'b0, acc[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
   wire [7:0] low8 = {1'b0, acc[6:0]} + {1'b0, addend[6:0]} + {7'h00, cin};
   wire add_cy = is_sub ? ~sum9[8] : sum9[8];
   wire add_ac = is_sub ? ~nib5[4] : nib5[4];
   wire add_ov = sum9[8] ^ low8[7];
   wire lg_dir = (lo == 4'h2) || (lo == 4'h3);
   wire [7:0] lg_a = lg_dir ? dir_val : acc;
   wire [7:0] lg_b = (lo == 4'h2) ? acc : ((lo == 4'h3) ? b2 : src);
   wire [7:0] logic_res = (hi == 4'h5) ? (lg_a & lg_b) :
                          (hi == 4'h4) ? (lg_a | lg_b) : (lg_a ^ lg_b);
   wire [15:0] prod = {8'h00, acc} * {8'h00, b};
   wire [7:0] div_b = (b == 8'h00) ? 8'h01 : b;
   wire [7:0] quo = acc / div_b;
   wire [7:0] rem = acc % div_b;

   // ---------------------------------------------------------------
   // Sequencing
   // ---------------------------------------------------------------
   wire is_br = (op == 8'h80) || (op == 8'h40) || (op == 8'h50) ||
                (op == 8'h60) || (op == 8'h70);
   wire br_cond = (op == 8'h80) || ((op == 8'h40) && cy) ||
                  ((op == 8'h50) && !cy) ||
                  ((op == 8'h60) && (acc == 8'h00)) ||
                  ((op == 8'h70) && (acc != 8'h00));
   wire taken = is_br && br_cond;
   wire cit_timing_s tim = op_timing(op);
   wire [3:0] clk_eff = tim.clk + {3'b000, taken};
   wire [3:0] last_cyc = clk_eff - 4'h1;
   wire last = ({1'b0, cyc} == last_cyc);
   wire stop_cond = dbg_ctl.halt || step_hit ||
                    (dbg_ctl.bp_en && (pc == dbg_ctl.bp_addr) && !bp_skip);
   wire go = !halted && !((cyc == 3'd0) && stop_cond);
   wire fetch = go && ({1'b0, cyc} < {2'b00, tim.len});
   wire is_code_space_load_instruction = (op == 8'h83) || (op == 8'h93);
   wire is_external_space_move_instruction = (op == 8'hE0) || (op == 8'hE2) || (op == 8'hE3) ||
                  (op == 8'hF0) || (op == 8'hF2) || (op == 8'hF3);
   wire external_space_move_instruction_go = go && (cyc == 3'd0) && is_external_space_move_instruction;
   wire [15:0] external_space_move_instruction_addr = op[1] ? {8'h00, ri_ptr} : dptr;
   wire [15:0] code_space_load_instruction_addr = {8'h00, acc} + (op[4] ? dptr : next_pc);
   wire [7:0] sp_inc = sp + 8'h01;

   // ---------------------------------------------------------------
   // Execute
   // ---------------------------------------------------------------
   always_comb begin
      next_acc = acc;
      next_b = b;
      next_psw = program_status_word;
      next_sp = sp;
      next_dptr = dptr;
      next_pc = fetch ? pc + 16'h0001 : pc;
      w_en = 1'b0;
      w_ind = 1'b0;
      w_addr = b1;
      w_data = 8'h00;
      if (halted) begin
         w_en = dbg_mem.req & dbg_mem.we;
         w_ind = ~dbg_mem.special_function_register_space;
         w_addr = dbg_mem.addr;
         w_data = dbg_mem.wdata;
      end else if (go && last) begin
         casez (op)
            8'h02: next_pc = {b1, b2};
            8'b???0_0001: next_pc = {pc[15:11], op[7:5], b1};
            8'h80, 8'h40, 8'h50, 8'h60, 8'h70: begin
               if (taken) begin
                  next_pc = pc + {{8{b1[7]}}, b1};
               end
            end
            8'b0010_01??, 8'b0010_1???, 8'b0011_01??, 8'b0011_1???,
            8'b1001_01??, 8'b1001_1???: begin
               next_acc = sum9[7:0];
               next_psw[PSW_CY] = add_cy;
               next_psw[PSW_AC] = add_ac;
               next_psw[PSW_OV] = add_ov;
            end
            8'b010?_01??, 8'b010?_1???, 8'b0110_01??, 8'b0110_1???:
               next_acc = logic_res;
            8'b010?_001?, 8'b0110_001?: begin
               w_en = 1'b1;
               w_data = logic_res;
            end
            8'h04: next_acc = acc + 8'h01;
            8'h14: next_acc = acc - 8'h01;
            8'b000?_01??, 8'b000?_1???: begin
               w_en = 1'b1;
               w_ind = dst_ind;
               w_addr = dst_addr;
               w_data = hi[0] ? src - 8'h01 : src + 8'h01;
            end
            8'hA3: next_dptr = dptr + 16'h0001;
            8'h90: next_dptr = {b1, b2};
            8'hE4: next_acc = 8'h00;
            8'hF4: next_acc = ~acc;
            8'h23: next_acc = {acc[6:0], acc[7]};
            8'h03: next_acc = {acc[0], acc[7:1]};
            8'h33: begin
               next_acc = {acc[6:0], cy};
               next_psw[PSW_CY] = acc[7];
            end
            8'h13: begin
               next_acc = {cy, acc[7:1]};
               next_psw[PSW_CY] = acc[0];
            end
            8'hC4: next_acc = {acc[3:0], acc[7:4]};
            8'h74, 8'hE5, 8'b1110_011?, 8'b1110_1???: next_acc = src;
            8'hF5, 8'b1111_011?, 8'b1111_1???: begin
               w_en = 1'b1;
               w_ind = dst_ind;
               w_addr = dst_addr;
               w_data = acc;
            end
            8'h75: begin
               w_en = 1'b1;
               w_data = b2;
            end
            8'h76, 8'h77, 8'b0111_1???: begin
               w_en = 1'b1;
               w_ind = 1'b1;
               w_addr = op[3] ? rn_addr : ri_ptr;
               w_data = b1;
            end
            8'b1100_1???: begin
               next_acc = rn_val;
               w_en = 1'b1;
               w_ind = 1'b1;
               w_addr = rn_addr;
               w_data = acc;
            end
            8'hC0: begin
               next_sp = sp_inc;
               w_en = 1'b1;
               w_ind = 1'b1;
               w_addr = sp_inc;
               w_data = dir_val;
            end
            8'hD0: begin
               next_sp = sp - 8'h01;
               w_en = 1'b1;
               w_data = iram[sp];
            end
            8'hA4: begin
               {next_b, next_acc} = prod;
               next_psw[PSW_CY] = 1'b0;
               next_psw[PSW_OV] = (prod[15:8] != 8'h00);
            end
            8'h84: begin
               next_psw[PSW_CY] = 1'b0;
               next_psw[PSW_OV] = (b == 8'h00);
               if (b != 8'h00) begin
                  next_acc = quo;
                  next_b = rem;
               end
            end
            8'h83, 8'h93: next_acc = code_rdata;
            8'hE0, 8'hE2, 8'hE3: next_acc = ext_rdata;
            default: next_pc = next_pc;
         endcase
      end
      // Direct writes that land on core registers.
      if (w_en && !w_ind) begin
         case (w_addr)
            A_ACC: next_acc = w_data;
            A_B: next_b = w_data;
            A_PSW: next_psw = w_data;
            A_SP: next_sp = w_data;
            A_DPL: next_dptr[7:0] = w_data;
            A_DPH: next_dptr[15:8] = w_data;
            default: next_sp = next_sp;
         endcase
      end
   end

   // The code port is steered away from the fetch stream for a code load.
   assign next_code_addr = (go && (cyc == 3'd0) && is_code_space_load_instruction) ? code_space_load_instruction_addr :
                           (go && (cyc == 3'd1) && is_code_space_load_instruction) ? code_addr :
                           next_pc;
   assign dbg_pc = pc;

   // ---------------------------------------------------------------
   // Memories
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (w_en && (w_ind || (w_addr < SFR_BASE))) begin
         iram[w_addr] <= w_data;
      end
      if (w_en && !w_ind && (w_addr >= SFR_BASE)) begin
         sfr_ram[w_addr[6:0]] <= w_data;
      end
   end

   // ---------------------------------------------------------------
   // Core registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         acc <= 8'h00;
         b <= 8'h00;
         program_status_word <= 8'h00;
         sp <= SP_RESET;
         dptr <= 16'h0000;
         pc <= PC_RESET;
         code_addr <= PC_RESET;
         flash_ctl <= 8'h00;
         cyc <= 3'd0;
         opcode_r <= 8'h00;
         op1 <= 8'h00;
         op2 <= 8'h00;
      end else begin
         acc <= next_acc;
         b <= next_b;
         program_status_word <= next_psw;
         sp <= next_sp;
         dptr <= next_dptr;
         pc <= next_pc;
         code_addr <= next_code_addr;
         if (w_en && !w_ind && (w_addr == A_FLCTL)) begin
            flash_ctl <= w_data;
         end
         if (go) begin
            cyc <= last ? 3'd0 : cyc + 3'd1;
         end
         if (go && (cyc == 3'd0)) begin
            opcode_r <= code_rdata;
         end
         if (go && (cyc == 3'd1)) begin
            op1 <= code_rdata;
         end
         if (go && (cyc == 3'd2)) begin
            op2 <= code_rdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // External data port
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ext <= '0;
      end else begin
         ext.we <= external_space_move_instruction_go & op[4];
         ext.re <= external_space_move_instruction_go & ~op[4];
         ext.flash <= external_space_move_instruction_go & op[4] & flash_ctl[0];
         if (external_space_move_instruction_go) begin
            ext.addr <= external_space_move_instruction_addr;
            ext.wdata <= acc;
         end
      end
   end

   // ---------------------------------------------------------------
   // Debug control
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         mode <= M_RUN;
         dbg_halted <= 1'b0;
         step_armed <= 1'b0;
         step_hit <= 1'b0;
         bp_skip <= 1'b0;
         dbg_mem_rdata <= 8'h00;
         dbg_mem_ack <= 1'b0;
      end else begin
         dbg_mem_ack <= halted & dbg_mem.req;
         dbg_mem_rdata <= dbg_mem.special_function_register_space ? dir_val : iram[dbg_mem.addr];
         case (mode)
            M_RUN: begin
               if ((cyc == 3'd0) && stop_cond) begin
                  mode <= M_HALT;
                  dbg_halted <= 1'b1;
                  step_armed <= 1'b0;
                  step_hit <= 1'b0;
               end else if (go && last) begin
                  bp_skip <= 1'b0;
                  step_hit <= step_armed;
               end
            end
            M_HALT: begin
               if (!dbg_ctl.halt && (dbg_ctl.run || dbg_ctl.step)) begin
                  mode <= M_RUN;
                  dbg_halted <= 1'b0;
                  step_armed <= dbg_ctl.step & ~dbg_ctl.run;
                  bp_skip <= 1'b1;
               end
            end
            default: mode <= M_HALT;
         endcase
      end
   end

endmodule : cit_core

// file: dv/cit_core_asserts.sv
// Purpose: Concurrent checks on the ports of the instruction core.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Attached to every core instance by the bind at the foot.

`timescale 1ns/1ps

module cit_core_asserts
   import cit_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [15:0] code_addr,
   input wire logic [7:0] code_rdata,
   input wire cit_ext_s ext,
   input wire logic [7:0] ext_rdata,
   input wire cit_dbg_ctl_s dbg_ctl,
   input wire cit_dbg_mem_s dbg_mem,
   input wire logic [7:0] dbg_mem_rdata,
   input wire logic dbg_mem_ack,
   input wire logic dbg_halted,
   input wire logic [15:0] dbg_pc
);
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence s_step_go;
      dbg_halted && dbg_ctl.step && !dbg_ctl.run && !dbg_ctl.halt;
   endsequence

   sequence s_one_instr;
      !dbg_halted ##[1:9] dbg_halted;
   endsequence

   reset_state_a: assert property (
      $rose(resetn) |-> code_addr == PC_RESET && dbg_pc == PC_RESET
         && !dbg_halted && !dbg_mem_ack)
      else $error("core state after reset is wrong");
   move_gap_a: assert property (
      ext.we || ext.re |=> !(ext.we || ext.re) [*2])
      else $error("external moves closer than three clocks");
   flash_write_a: assert property (
      ext.flash |-> ext.we && !ext.re)
      else $error("flash pulse without a write");
   ack_follow_a: assert property (
      dbg_halted && dbg_mem.req |=> dbg_mem_ack)
      else $error("debug access while halted not acknowledged");
   ack_cause_a: assert property (
      dbg_mem_ack |-> $past(dbg_mem.req) && $past(dbg_halted))
      else $error("debug acknowledge without a halted request");
   halt_hold_a: assert property (
      dbg_halted && !dbg_ctl.run && !dbg_ctl.step
         |=> dbg_halted && $stable(code_addr) && !ext.we)
      else $error("core moved while halted");
   halt_reach_a: assert property (
      dbg_ctl.halt && !dbg_halted |-> ##[1:9] dbg_halted)
      else $error("halt not reached within one instruction");
   step_once_a: assert property (
      s_step_go |=> s_one_instr)
      else $error("single step did not stop again");
   no_stall_a: assert property (
      !dbg_halted |-> ##[0:8] ($changed(code_addr) || dbg_halted))
      else $error("running core held its fetch too long");

endmodule : cit_core_asserts

bind cit_core cit_core_asserts u_chk (
   .clk_sys(clk_sys),
   .resetn(resetn),
   .code_addr(code_addr),
   .code_rdata(code_rdata),
   .ext(ext),
   .ext_rdata(ext_rdata),
   .dbg_ctl(dbg_ctl),
   .dbg_mem(dbg_mem),
   .dbg_mem_rdata(dbg_mem_rdata),
   .dbg_mem_ack(dbg_mem_ack),
   .dbg_halted(dbg_halted),
   .dbg_pc(dbg_pc)
);

// file: dv/cit_mem_model.sv
// Purpose: Program flash and external data memory beside the core.
// Assumes: Code reads are combinational; move reads answer next cycle.
// Notes:   Only the low address byte selects a location.

`timescale 1ns/1ps

module cit_mem_model
   import cit_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [15:0] code_addr,
   output logic [7:0] code_rdata,
   input wire cit_ext_s ext,
   output logic [7:0] ext_rdata
);
   logic [7:0] code [0:255];
   logic [7:0] xram [0:255];
   logic rd_live = 1'b0;
   logic [7:0] junk = 8'h5A;

   assign code_rdata = code[code_addr[7:0]];
   // Read data is only valid in the cycle after the read pulse.
   assign ext_rdata = rd_live ? xram[ext.addr[7:0]] : junk;

   always @(posedge clk_sys) begin
      rd_live <= ext.re;
      junk <= junk + 8'h3B;
      if (ext.we && ext.flash) begin
         code[ext.addr[7:0]] <= ext.wdata;
      end else if (ext.we) begin
         xram[ext.addr[7:0]] <= ext.wdata;
      end
   end

endmodule : cit_mem_model

// file: dv/testbench.sv
// Purpose: Self-checking bench for the instruction core.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Timing is measured between external write pulses.

`timescale 1ns/1ps

module testbench
   import cit_pkg::*;
;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [15:0] code_addr, dbg_pc;
   logic [7:0] code_rdata, ext_rdata, dbg_mem_rdata;
   logic dbg_mem_ack, dbg_halted;
   cit_ext_s ext;
   cit_dbg_ctl_s dbg_ctl = '0;
   cit_dbg_mem_s dbg_mem = '0;
   int n_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   cit_ext_s wr_q[$];
   int wr_t[$];

   always #12.5 clk_sys = ~clk_sys;

   cit_core dut (.clk_sys(clk_sys), .resetn(resetn), .code_addr(code_addr),
      .code_rdata(code_rdata), .ext(ext), .ext_rdata(ext_rdata),
      .dbg_ctl(dbg_ctl), .dbg_mem(dbg_mem), .dbg_mem_rdata(dbg_mem_rdata),
      .dbg_mem_ack(dbg_mem_ack), .dbg_halted(dbg_halted), .dbg_pc(dbg_pc));
   cit_mem_model u_mem (.clk_sys(clk_sys), .code_addr(code_addr),
      .code_rdata(code_rdata), .ext(ext), .ext_rdata(ext_rdata));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
         input string what);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t %s: saw %h want %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic test_done();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done

   always @(posedge clk_sys) begin
      cycles++;
      if (ext.we) begin
         wr_q.push_back(ext);
         wr_t.push_back(cycles);
      end
      if (cycles == 20000) begin
         n_errors++;
         test_done();
      end
   end

   function automatic cit_ext_s w(input logic [15:0] a, input logic [7:0] d,
         input logic f);
      return '{a, d, 1'b1, 1'b0, f};
   endfunction : w

   // Loads a program, resets, and compares every external write and the
   // clock gap between consecutive writes.
   task automatic run_prog(input logic [7:0] prog[$], input cit_ext_s ew[$],
         input int gaps[$]);
      int n;
      resetn = 1'b0;
      for (int i = 0; i < 256; i++) begin
         u_mem.code[i] = 8'h00;
      end
      foreach (prog[i]) begin
         u_mem.code[i] = prog[i];
      end
      @(negedge clk_sys);
      check({ext, dbg_halted, dbg_mem_ack}, 32'h0000_0000, "reset out");
      check(code_addr, PC_RESET, "reset pc");
      wr_q.delete();
      wr_t.delete();
      @(negedge clk_sys);
      resetn = 1'b1;
      n = 0;
      while (wr_q.size() < ew.size() && n < 200) begin
         @(negedge clk_sys);
         n++;
      end
      check(wr_q.size(), ew.size(), "write count");
      for (int i = 0; i < wr_q.size() && i < ew.size(); i++) begin
         check(wr_q[i], ew[i], "write beat");
         if (i > 0) begin
            check(wr_t[i] - wr_t[i - 1], gaps[i - 1], "gap");
         end
      end
   endtask : run_prog

   task automatic dmem(input logic we, input logic special_function_register_space, input logic [7:0] a,
         input logic [7:0] d, input logic ack, output logic [7:0] rd);
      dbg_mem = '{1'b1, we, special_function_register_space, a, d};
      @(negedge clk_sys);
      check(dbg_mem_ack, ack, "debug ack");
      rd = dbg_mem_rdata;
      dbg_mem.req = 1'b0;
      @(negedge clk_sys);
   endtask : dmem

   task automatic wait_halt(input logic v);
      int n;
      n = 0;
      while (dbg_halted !== v && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      check(dbg_halted, v, "halt state");
   endtask : wait_halt

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_arith();
      cit_ext_s e[$];
      e = '{w(16'h0000, 8'h00, 1'b0), w(16'h0000, 8'h2A, 1'b0),
         w(16'h0000, 8'h08, 1'b0), w(16'h0000, 8'h81, 1'b0)};
      // Three one-clock no-ops, multiply 6*7, divide 42/5, then add
      // 0xF0 and 0x20 and store the status word with carry and parity.
      run_prog('{8'hF0, 8'h00, 8'h00, 8'h00, 8'h74, 8'h06, 8'h75, 8'hF0,
         8'h07, 8'hA4, 8'hF0, 8'h75, 8'hF0, 8'h05, 8'h84, 8'hF0, 8'h74,
         8'hF0, 8'h24, 8'h20, 8'hE5, A_PSW, 8'hF0}, e,
         '{15, 14, 9});
   endtask : t_arith

   task automatic t_branches();
      logic [7:0] op[4];
      int gap[4];
      cit_ext_s e[$];
      op = '{8'h40, 8'h50, 8'h60, 8'h70};
      gap = '{9, 8, 8, 9};
      e = '{w(16'h0000, 8'h00, 1'b0), w(16'h0000, 8'h00, 1'b0)};
      for (int k = 0; k < 4; k++) begin
         run_prog('{8'hF0, 8'h74, 8'h00, op[k], 8'h02, 8'h00, 8'h00,
            8'hF0}, e, '{gap[k]});
      end
   endtask : t_branches

   task automatic t_flash();
      cit_ext_s e[$];
      e = '{w(16'h0040, 8'h5A, 1'b1), w(16'h0040, 8'h5A, 1'b0),
         w(16'h0040, 8'h5A, 1'b0)};
      // The last move reads the data byte back after clearing the
      // accumulator, so the read path must deliver it.
      run_prog('{8'h75, A_FLCTL, 8'h01, 8'h90, 8'h00, 8'h40, 8'h74, 8'h5A,
         8'hF0, 8'h74, 8'h00, 8'h93, 8'h75, A_FLCTL, 8'h00, 8'hF0,
         8'h74, 8'h00, 8'hE0, 8'hF0}, e,
         '{11, 8});
      check(u_mem.code[64], 8'h5A, "flash byte");
   endtask : t_flash

   task automatic t_debug();
      logic [15:0] pc0;
      logic [7:0] rd;
      run_prog('{8'h00}, '{}, '{});
      dbg_ctl.halt = 1'b1;
      wait_halt(1'b1);
      dbg_ctl.halt = 1'b0;
      pc0 = dbg_pc;
      repeat (3) @(negedge clk_sys);
      check(dbg_pc, pc0, "halted pc");
      check(code_addr, pc0, "halted fetch");
      dmem(1'b1, 1'b0, 8'hE0, 8'h11, 1'b1, rd);
      dmem(1'b1, 1'b1, A_ACC, 8'h22, 1'b1, rd);
      dmem(1'b0, 1'b0, 8'hE0, 8'h00, 1'b1, rd);
      check(rd, 8'h11, "ram byte");
      dmem(1'b0, 1'b1, A_ACC, 8'h00, 1'b1, rd);
      check(rd, 8'h22, "sfr byte");
      dbg_ctl.step = 1'b1;
      @(negedge clk_sys);
      dbg_ctl.step = 1'b0;
      check(dbg_halted, 1'b0, "step leaves halt");
      wait_halt(1'b1);
      check(dbg_pc, pc0 + 16'h0001, "step pc");
      dbg_ctl.bp_en = 1'b1;
      dbg_ctl.bp_addr = pc0 + 16'h0006;
      dbg_ctl.run = 1'b1;
      @(negedge clk_sys);
      dbg_ctl.run = 1'b0;
      wait_halt(1'b0);
      wait_halt(1'b1);
      check(dbg_pc, pc0 + 16'h0006, "breakpoint pc");
      dbg_ctl.bp_en = 1'b0;
      dbg_ctl.run = 1'b1;
      @(negedge clk_sys);
      dbg_ctl.run = 1'b0;
      @(negedge clk_sys);
      dmem(1'b0, 1'b0, 8'hE0, 8'h00, 1'b0, rd);
   endtask : t_debug

   initial begin
      repeat (12) @(negedge clk_sys);
      resetn = 1'b1;
      @(negedge clk_sys);
      t_arith();
      t_branches();
      t_flash();
      t_debug();
      test_done();
   end

endmodule : testbench
